// >>> common/bsu_pkg.sv
package bsu_pkg;
  // clock and timing
  localparam int CLK_MHZ = 50;
  localparam int DRAM_IDLE_US = 100;
  localparam int DRAM_IDLE_CYCLES = DRAM_IDLE_US * CLK_MHZ;
  localparam int DRAM_WAKE_ACCESSES = 8;
  localparam int RESET_HOLD_CYCLES = 16;

  // internal block and dual-port RAM
  localparam int BLOCK_BITS = 13;
  localparam int SYS_RAM_BYTES = 1762;
  localparam int PARAM_RAM_BYTES = 768;
  localparam int RAM_BYTES = SYS_RAM_BYTES + PARAM_RAM_BYTES;
  localparam int RAM_AW = 12;

  // module base register, at a fixed address
  localparam logic [31:0] MODULE_BASE_ADDR = 32'hFFFF_FF00;
  localparam logic [31:0] MODULE_BASE_RESET = 32'h0000_0000;
  localparam int MODULE_BASE_REGISTER_VALID_BIT = 0;

  // register offsets inside the 8 Kbyte block
  localparam logic [12:0] OFS_CLK_OUT = 13'h1000;
  localparam logic [12:0] OFS_SYNTH = 13'h1004;
  localparam logic [12:0] OFS_DIVIDER = 13'h1008;
  localparam logic [12:0] OFS_CAUSE = 13'h100C;
  localparam logic [12:0] OFS_PIN_FUNC = 13'h1010;
  localparam logic [12:0] OFS_GLOBAL_MEM = 13'h1014;
  localparam logic [12:0] OFS_BANK0_OPT = 13'h1018;
  localparam logic [12:0] OFS_BANK0_BASE = 13'h101C;
  localparam logic [12:0] OFS_COMMAND = 13'h1020;
  localparam logic [12:0] OFS_DRAM_STAT = 13'h1024;

  // clock synthesiser
  localparam logic [15:0] SYNTH_LOCK_VALUE = 16'h8000;
  localparam logic [15:0] CLK_REG_RESET = 16'h0000;

  // reset cause bits
  localparam int CAUSE_EXT = 7;
  localparam int CAUSE_POR = 6;
  localparam int CAUSE_WDOG = 5;
  localparam int CAUSE_DBLF = 4;
  localparam int CAUSE_BUSMON = 3;
  localparam logic [7:0] CAUSE_RESET = 8'h40;

  // boot chip select and bank 0
  localparam logic [3:0] BOOT_WAIT_MAX = 4'hF;
  localparam logic [31:0] BOOT_SP_ADDR = 32'h0000_0000;
  localparam logic [31:0] BOOT_PC_ADDR = 32'h0000_0004;
  localparam int BANK0_VALID_BIT = 0;
  localparam logic [31:0] BANK0_FIELD_MASK = 32'hFFFF_F800;

  // function codes
  localparam logic [3:0] FC_SUPER_PROG = 4'h6;
  localparam logic [3:0] FC_SUPER_DATA = 4'h5;
  localparam logic [3:0] FC_USER_PROG = 4'h2;
  localparam logic [3:0] FC_USER_DATA = 4'h1;

  // command register and pin function
  localparam int CMD_FLAG_BIT = 0;
  localparam logic [7:0] CMD_CP_RESET = 8'h80;
  localparam int PIN_WE_BIT = 0;

  typedef enum logic [1:0] {
    SEQ_HOLD,
    SEQ_FETCH_SP,
    SEQ_FETCH_PC,
    SEQ_RUN
  } bsu_seq_type;
endpackage : bsu_pkg

// >>> verilog/bsu_dpram.sv
module bsu_dpram #(
  parameter int BYTES = bsu_pkg::RAM_BYTES
) (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [bsu_pkg::RAM_AW-1:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  // no reset: contents are unpredictable after power-on
  logic [7:0] mem [BYTES];
  logic [7:0] rdata_q;

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[addr] <= wdata;
    end
    if (rd_en) begin
      rdata_q <= mem[addr];
    end
  end

  assign rdata = rdata_q;
endmodule : bsu_dpram

// >>> verilog/bsu_boot_setup.sv
// How it works
// R1 - after any reset boot select spans everything, slow
// R2 - fetch stack pointer, then program counter from boot
// R3 - leave reset in supervisor; supervisor function codes
// R4 - fixed-address base register places the internal block
// R5 - base 00700001 puts internal RAM at 700000
// R6 - firmware sets the base before internal accesses
// R7 - first internal RAM byte reads back written pattern
// R8 - record reset cause; writing ones clears bits
// R9 - msb-only synthesiser write locks clock registers
// R10 - dual-port RAM is left uninitialised at power-on
// R11 - reset command makes engine reinitialise channel state
// R12 - pin function register selects shared bus pin use
// R13 - firmware remaps bank 0, setting valid last
// R14 - DRAM waits idle then eight reads or refreshes
// R15 - base register low bit enables the internal block
module bsu_boot_setup #(
  parameter int DRAM_IDLE_CYCLES = bsu_pkg::DRAM_IDLE_CYCLES,
  parameter int RAM_BYTES = bsu_pkg::RAM_BYTES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ext_reset_req,
  input wire logic watchdog_reset_req,
  input wire logic bus_monitor_reset_req,
  input wire logic double_fault_reset_req,
  output logic core_reset,
  output logic core_run,
  output logic [31:0] init_sp,
  output logic [31:0] init_pc,
  output logic boot_rd_req,
  output logic [31:0] boot_rd_addr,
  input wire logic [31:0] boot_rd_data,
  input wire logic boot_rd_ack,
  input wire logic core_fetch,
  input wire logic core_leave_supervisor,
  output logic [3:0] core_fc,
  output logic supervisor_mode,
  input wire logic acc_valid,
  input wire logic acc_write,
  input wire logic [31:0] acc_addr,
  input wire logic [31:0] acc_wdata,
  output logic [31:0] acc_rdata,
  output logic acc_ready,
  output logic acc_internal,
  input wire logic [31:0] sys_addr,
  output logic boot_chip_select,
  output logic [3:0] boot_wait_states,
  output logic cp_reinit,
  input wire logic cp_reinit_done,
  output logic [15:0] pin_function,
  output logic addr_pins_as_write_enables,
  output logic [31:0] global_memory_config,
  output logic [15:0] clock_output_control,
  output logic [15:0] synthesiser_control,
  output logic [15:0] clock_divider_control,
  output logic synth_locked,
  input wire logic dram_read_seen,
  input wire logic dram_refresh_seen,
  output logic dram_ready
);
  localparam int IDLE_W = $clog2(DRAM_IDLE_CYCLES + 1);
  localparam logic [4:0] HOLD_LAST = 5'(bsu_pkg::RESET_HOLD_CYCLES - 1);
  localparam logic [3:0] WAKE_N = 4'(bsu_pkg::DRAM_WAKE_ACCESSES);

  // ---------------- reset and vector fetch sequencer
  bsu_pkg::bsu_seq_type seq_q, seq_d;
  logic [4:0] hold_q, hold_d;
  logic [31:0] sp_q, sp_d, pc_q, pc_d;
  logic super_q, super_d;
  logic any_req;

  assign any_req = ext_reset_req | watchdog_reset_req | bus_monitor_reset_req
                   | double_fault_reset_req;

  always_comb begin
    seq_d = seq_q;
    hold_d = hold_q;
    sp_d = sp_q;
    pc_d = pc_q;
    super_d = super_q;
    case (seq_q)
      bsu_pkg::SEQ_HOLD: begin
        if (hold_q != 5'h0) begin
          hold_d = hold_q - 5'h1;
        end else begin
          seq_d = bsu_pkg::SEQ_FETCH_SP;
        end
      end
      bsu_pkg::SEQ_FETCH_SP: begin
        if (boot_rd_ack) begin
          sp_d = boot_rd_data; // [R2]
          seq_d = bsu_pkg::SEQ_FETCH_PC;
        end
      end
      bsu_pkg::SEQ_FETCH_PC: begin
        if (boot_rd_ack) begin
          pc_d = boot_rd_data; // [R2]
          seq_d = bsu_pkg::SEQ_RUN;
        end
      end
      bsu_pkg::SEQ_RUN: begin
        if (core_leave_supervisor) begin
          super_d = 1'b0;
        end
      end
      default: begin
        seq_d = bsu_pkg::SEQ_HOLD;
      end
    endcase
    if (seq_q != bsu_pkg::SEQ_RUN) begin
      super_d = 1'b1; // [R3]
    end
    if (any_req) begin
      seq_d = bsu_pkg::SEQ_HOLD;
      hold_d = HOLD_LAST;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      seq_q <= bsu_pkg::SEQ_HOLD;
      hold_q <= HOLD_LAST;
      sp_q <= 32'h0000_0000;
      pc_q <= 32'h0000_0000;
      super_q <= 1'b1;
    end else begin
      seq_q <= seq_d;
      hold_q <= hold_d;
      sp_q <= sp_d;
      pc_q <= pc_d;
      super_q <= super_d;
    end
  end

  logic in_hold, running;
  assign in_hold = seq_q == bsu_pkg::SEQ_HOLD;
  assign running = seq_q == bsu_pkg::SEQ_RUN;
  assign core_reset = !running;
  assign core_run = running;
  assign init_sp = sp_q;
  assign init_pc = pc_q;
  assign boot_rd_req = (seq_q == bsu_pkg::SEQ_FETCH_SP) || (seq_q == bsu_pkg::SEQ_FETCH_PC);
  assign boot_rd_addr = (seq_q == bsu_pkg::SEQ_FETCH_PC) ? bsu_pkg::BOOT_PC_ADDR
                                                         : bsu_pkg::BOOT_SP_ADDR; // [R2]
  assign supervisor_mode = super_q;
  always_comb begin
    if (super_q) begin
      core_fc = core_fetch ? bsu_pkg::FC_SUPER_PROG : bsu_pkg::FC_SUPER_DATA; // [R3]
    end else begin
      core_fc = core_fetch ? bsu_pkg::FC_USER_PROG : bsu_pkg::FC_USER_DATA;
    end
  end

  // ---------------- register file and access port
  logic [31:0] module_base_register_q, module_base_register_d, gmc_q, gmc_d, opt_q, opt_d, base_q, base_d;
  logic [15:0] clko_q, clko_d, synth_q, synth_d, div_q, div_d;
  logic [15:0] pin_q, pin_d, cmd_q, cmd_d;
  logic [7:0] cause_q, cause_d;
  logic lock_q, lock_d, reinit_q, reinit_d;
  logic [31:0] rdata_q, rdata_d;
  logic ready_q, ready_d, ram_sel_q, ram_sel_d;
  logic module_base_register_hit, blk_hit, ram_hit, take, wr;
  logic [12:0] ofs;
  logic [7:0] ram_rdata;
  logic dram_ready_q;

  assign module_base_register_hit = acc_addr == bsu_pkg::MODULE_BASE_ADDR; // [R4]
  assign blk_hit = module_base_register_q[bsu_pkg::MODULE_BASE_REGISTER_VALID_BIT]
                   && (acc_addr[31:13] == module_base_register_q[31:13]); // [R4] [R5] [R15]
  assign ofs = acc_addr[12:0];
  assign ram_hit = blk_hit && !module_base_register_hit && (ofs < 13'(RAM_BYTES));
  assign take = acc_valid && running && (module_base_register_hit || blk_hit);
  assign wr = take && acc_write;
  assign acc_internal = blk_hit;

  always_comb begin
    module_base_register_d = module_base_register_q;
    gmc_d = gmc_q;
    opt_d = opt_q;
    base_d = base_q;
    clko_d = clko_q;
    synth_d = synth_q;
    div_d = div_q;
    pin_d = pin_q;
    cmd_d = cmd_q;
    cause_d = cause_q;
    lock_d = lock_q;
    reinit_d = 1'b0;
    rdata_d = 32'h0000_0000;
    ready_d = take;
    ram_sel_d = take && ram_hit;
    if (cmd_q[bsu_pkg::CMD_FLAG_BIT] && cp_reinit_done) begin
      cmd_d[bsu_pkg::CMD_FLAG_BIT] = 1'b0;
    end
    if (wr && module_base_register_hit) begin
      module_base_register_d = acc_wdata; // [R4] [R5]
    end else if (wr) begin
      case (ofs)
        bsu_pkg::OFS_CLK_OUT: begin
          if (!lock_q) clko_d = acc_wdata[15:0]; // [R9]
        end
        bsu_pkg::OFS_SYNTH: begin
          if (!lock_q) begin
            synth_d = acc_wdata[15:0];
            lock_d = acc_wdata[15:0] == bsu_pkg::SYNTH_LOCK_VALUE; // [R9]
          end
        end
        bsu_pkg::OFS_DIVIDER: begin
          if (!lock_q) div_d = acc_wdata[15:0]; // [R9]
        end
        bsu_pkg::OFS_CAUSE: begin
          cause_d = cause_q & ~acc_wdata[7:0]; // [R8]
        end
        bsu_pkg::OFS_PIN_FUNC: begin
          pin_d = acc_wdata[15:0]; // [R12]
        end
        bsu_pkg::OFS_GLOBAL_MEM: begin
          gmc_d = acc_wdata;
        end
        bsu_pkg::OFS_BANK0_OPT: begin
          opt_d = acc_wdata;
        end
        bsu_pkg::OFS_BANK0_BASE: begin
          base_d = acc_wdata; // [R13]
        end
        bsu_pkg::OFS_COMMAND: begin
          if (!cmd_q[bsu_pkg::CMD_FLAG_BIT] && acc_wdata[bsu_pkg::CMD_FLAG_BIT]
              && (acc_wdata[15:8] == bsu_pkg::CMD_CP_RESET)) begin
            cmd_d = acc_wdata[15:0];
            reinit_d = 1'b1; // [R11]
          end
        end
        default: begin
        end
      endcase
    end
    if (take && !acc_write && !module_base_register_hit) begin
      case (ofs)
        bsu_pkg::OFS_CLK_OUT: rdata_d = {16'h0000, clko_q};
        bsu_pkg::OFS_SYNTH: rdata_d = {16'h0000, synth_q};
        bsu_pkg::OFS_DIVIDER: rdata_d = {16'h0000, div_q};
        bsu_pkg::OFS_CAUSE: rdata_d = {24'h00_0000, cause_q}; // [R8]
        bsu_pkg::OFS_PIN_FUNC: rdata_d = {16'h0000, pin_q};
        bsu_pkg::OFS_GLOBAL_MEM: rdata_d = gmc_q;
        bsu_pkg::OFS_BANK0_OPT: rdata_d = opt_q;
        bsu_pkg::OFS_BANK0_BASE: rdata_d = base_q;
        bsu_pkg::OFS_COMMAND: rdata_d = {16'h0000, cmd_q};
        bsu_pkg::OFS_DRAM_STAT: rdata_d = {31'h0000_0000, dram_ready_q};
        default: rdata_d = 32'h0000_0000;
      endcase
    end else if (take && !acc_write) begin
      rdata_d = module_base_register_q;
    end
    // set wins over the write-one clear
    if (ext_reset_req) cause_d[bsu_pkg::CAUSE_EXT] = 1'b1; // [R8]
    if (watchdog_reset_req) cause_d[bsu_pkg::CAUSE_WDOG] = 1'b1; // [R8]
    if (double_fault_reset_req) cause_d[bsu_pkg::CAUSE_DBLF] = 1'b1; // [R8]
    if (bus_monitor_reset_req) cause_d[bsu_pkg::CAUSE_BUSMON] = 1'b1; // [R8]
    // any reset restores the boot view; clocks, lock and cause persist over reset requests but not over rst
    if (in_hold) begin
      module_base_register_d = bsu_pkg::MODULE_BASE_RESET;
      gmc_d = 32'h0000_0000;
      opt_d = 32'h0000_0000;
      base_d = 32'h0000_0000; // [R1]
      pin_d = 16'h0000;
      cmd_d = 16'h0000;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      module_base_register_q <= bsu_pkg::MODULE_BASE_RESET;
      gmc_q <= 32'h0000_0000;
      opt_q <= 32'h0000_0000;
      base_q <= 32'h0000_0000;
      clko_q <= bsu_pkg::CLK_REG_RESET;
      synth_q <= bsu_pkg::CLK_REG_RESET;
      div_q <= bsu_pkg::CLK_REG_RESET;
      pin_q <= 16'h0000;
      cmd_q <= 16'h0000;
      cause_q <= bsu_pkg::CAUSE_RESET; // [R8]
      lock_q <= 1'b0;
      reinit_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      ready_q <= 1'b0;
      ram_sel_q <= 1'b0;
    end else begin
      module_base_register_q <= module_base_register_d;
      gmc_q <= gmc_d;
      opt_q <= opt_d;
      base_q <= base_d;
      clko_q <= clko_d;
      synth_q <= synth_d;
      div_q <= div_d;
      pin_q <= pin_d;
      cmd_q <= cmd_d;
      cause_q <= cause_d;
      lock_q <= lock_d;
      reinit_q <= reinit_d;
      rdata_q <= rdata_d;
      ready_q <= ready_d;
      ram_sel_q <= ram_sel_d;
    end
  end

  // internal RAM at the start of the block
  bsu_dpram #(
    .BYTES(RAM_BYTES)
  ) u_dpram (
    .clk(clk),
    .wr_en(wr && ram_hit), // [R7]
    .rd_en(take && !acc_write && ram_hit),
    .addr(ofs[bsu_pkg::RAM_AW-1:0]),
    .wdata(acc_wdata[7:0]),
    .rdata(ram_rdata) // [R10]
  );

  assign acc_ready = ready_q;
  assign acc_rdata = ram_sel_q ? {24'h00_0000, ram_rdata} : rdata_q; // [R7]
  assign cp_reinit = reinit_q; // [R11]
  assign pin_function = pin_q;
  assign addr_pins_as_write_enables = pin_q[bsu_pkg::PIN_WE_BIT]; // [R12]
  assign global_memory_config = gmc_q;
  assign clock_output_control = clko_q;
  assign synthesiser_control = synth_q;
  assign clock_divider_control = div_q;
  assign synth_locked = lock_q;

  // boot select: whole space with maximum waits until bank 0 is valid
  logic b0_valid;
  assign b0_valid = base_q[bsu_pkg::BANK0_VALID_BIT];
  assign boot_chip_select = !b0_valid
                            || ((((sys_addr ^ base_q) & opt_q) & bsu_pkg::BANK0_FIELD_MASK)
                                == 32'h0000_0000); // [R1] [R13]
  assign boot_wait_states = b0_valid ? opt_q[3:0] : bsu_pkg::BOOT_WAIT_MAX; // [R1]

  // ---------------- DRAM start-up: idle time, then wake accesses
  logic [IDLE_W-1:0] idle_q, idle_d;
  logic [3:0] wake_q, wake_d;
  logic dram_ready_d;

  always_comb begin
    idle_d = idle_q;
    wake_d = wake_q;
    if (idle_q != '0) begin
      idle_d = idle_q - IDLE_W'(1); // [R14]
    end else if ((wake_q != WAKE_N) && (dram_read_seen || dram_refresh_seen)) begin
      wake_d = wake_q + 4'h1; // [R14]
    end
    dram_ready_d = (idle_q == '0) && (wake_q == WAKE_N);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      idle_q <= IDLE_W'(DRAM_IDLE_CYCLES);
      wake_q <= 4'h0;
      dram_ready_q <= 1'b0;
    end else begin
      idle_q <= idle_d;
      wake_q <= wake_d;
      dram_ready_q <= dram_ready_d;
    end
  end

  assign dram_ready = dram_ready_q;
endmodule : bsu_boot_setup

// >>> verification/bsu_boot_setup_sva.sv
module bsu_boot_setup_sva #(
  parameter int DRAM_IDLE_CYCLES = bsu_pkg::DRAM_IDLE_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic core_reset,
  input wire logic core_run,
  input wire logic [31:0] init_pc,
  input wire logic boot_rd_req,
  input wire logic [31:0] boot_rd_addr,
  input wire logic [31:0] boot_rd_data,
  input wire logic boot_rd_ack,
  input wire logic core_fetch,
  input wire logic [3:0] core_fc,
  input wire logic supervisor_mode,
  input wire logic acc_valid,
  input wire logic [31:0] acc_addr,
  input wire logic acc_ready,
  input wire logic boot_chip_select,
  input wire logic [3:0] boot_wait_states,
  input wire logic cp_reinit,
  input wire logic [15:0] synthesiser_control,
  input wire logic synth_locked,
  input wire logic dram_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] up_q;
  logic [15:0] up_d;
  // cycles since power-on release, saturating
  always_comb begin
    up_d = (up_q == 16'hFFFF) ? up_q : up_q + 16'h1;
    if (rst) begin
      up_d = 16'h0;
    end
  end
  always_ff @(posedge clk) begin
    up_q <= up_d;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  AST_RESET_BOOT: assert property ($fell(rst) |-> boot_chip_select && core_reset
    && boot_wait_states == 4'hF) else $error("boot select not wide and slow after reset");
  AST_SUPER_RESET: assert property ($fell(rst) |-> supervisor_mode)
    else $error("not supervisor after reset");
  AST_FETCH_ORDER: assert property (boot_rd_req && boot_rd_ack && boot_rd_addr == 32'h0
    |=> boot_rd_req && boot_rd_addr == 32'h4) else $error("pc fetch does not follow sp");
  AST_RUN_AFTER_PC: assert property (boot_rd_req && boot_rd_ack && boot_rd_addr == 32'h4
    |=> core_run && init_pc == $past(boot_rd_data)) else $error("run or pc wrong after fetch");
  AST_FC: assert property (core_fc == {1'h0, supervisor_mode, core_fetch, !core_fetch})
    else $error("function code wrong");
  AST_BASE_ANSWER: assert property (acc_valid && core_run && acc_addr == 32'hFFFF_FF00
    |=> acc_ready) else $error("base register not answered");
  AST_REFUSE_IDLE: assert property (!core_run |=> !acc_ready)
    else $error("access answered outside run");
  AST_LOCK: assert property (synth_locked |=> synth_locked && $stable(synthesiser_control))
    else $error("locked synthesiser changed");
  AST_DRAM_WAIT: assert property (int'(up_q) < DRAM_IDLE_CYCLES |-> !dram_ready)
    else $error("dram ready before idle time");
  cover property (core_run && acc_ready);
  cover property (synth_locked);
  cover property (cp_reinit);
  cover property (dram_ready);
endmodule : bsu_boot_setup_sva

bind bsu_boot_setup bsu_boot_setup_sva #(.DRAM_IDLE_CYCLES(DRAM_IDLE_CYCLES)) bsu_sva_inst (
  .clk(clk), .rst(rst), .core_reset(core_reset), .core_run(core_run), .init_pc(init_pc),
  .boot_rd_req(boot_rd_req), .boot_rd_addr(boot_rd_addr), .boot_rd_data(boot_rd_data),
  .boot_rd_ack(boot_rd_ack), .core_fetch(core_fetch), .core_fc(core_fc),
  .supervisor_mode(supervisor_mode), .acc_valid(acc_valid), .acc_addr(acc_addr),
  .acc_ready(acc_ready), .boot_chip_select(boot_chip_select),
  .boot_wait_states(boot_wait_states), .cp_reinit(cp_reinit),
  .synthesiser_control(synthesiser_control), .synth_locked(synth_locked),
  .dram_ready(dram_ready));

// >>> verification/bsu_boot_mem.sv
module bsu_boot_mem #(
  parameter logic [31:0] SP_WORD = 32'h0040_0000,
  parameter logic [31:0] PC_WORD = 32'h0000_0400
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] delay,
  input wire logic req,
  input wire logic [31:0] addr,
  output logic ack,
  output logic [31:0] data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt;
  always_ff @(posedge clk) begin
    data <= rst ? 32'h5A5A_5A5A : ~data; // released bus toggles
    if (rst || !req || ack) begin
      cnt <= 4'h0;
      ack <= 1'b0;
    end else if (cnt == delay) begin
      ack <= 1'b1;
      data <= (addr == 32'h4) ? PC_WORD : SP_WORD;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule : bsu_boot_mem

// >>> verification/bsu_boot_setup_tb.sv
module bsu_boot_setup_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] BASE = 32'h0070_0000;
  localparam logic [31:0] MODULE_BASE_REGISTER = 32'hFFFF_FF00;
  typedef struct {logic w; logic [12:0] ofs; logic [31:0] wd; logic [31:0] exp;} bsu_row_type;
  logic clk, rst, ext_reset_req, watchdog_reset_req, bus_monitor_reset_req;
  logic double_fault_reset_req, core_reset, core_run, boot_rd_req, boot_rd_ack, core_fetch;
  logic core_leave_supervisor, supervisor_mode, acc_valid, acc_write, acc_ready, boot_chip_select;
  logic cp_reinit, cp_reinit_done, addr_pins_as_write_enables, synth_locked;
  logic dram_read_seen, dram_refresh_seen, dram_ready, ok;
  logic [31:0] init_sp, init_pc, boot_rd_addr, boot_rd_data, acc_addr, acc_wdata, acc_rdata;
  logic [31:0] sys_addr, rd;
  logic [15:0] synthesiser_control;
  logic [3:0] core_fc, boot_wait_states, mem_delay;
  logic [31:0] gmc;
  logic [15:0] pin_func, clk_out, clk_div;
  logic acc_int;
  bsu_row_type rows [14];
  logic [7:0] cause [4];
  int n_fail, n_tests, k, i;

  bsu_boot_setup #(.DRAM_IDLE_CYCLES(20)) bsu_boot_setup_inst (
    .clk(clk), .rst(rst), .ext_reset_req(ext_reset_req), .watchdog_reset_req(watchdog_reset_req),
    .bus_monitor_reset_req(bus_monitor_reset_req), .double_fault_reset_req(double_fault_reset_req),
    .core_reset(core_reset), .core_run(core_run), .init_sp(init_sp), .init_pc(init_pc),
    .boot_rd_req(boot_rd_req), .boot_rd_addr(boot_rd_addr), .boot_rd_data(boot_rd_data),
    .boot_rd_ack(boot_rd_ack), .core_fetch(core_fetch),
    .core_leave_supervisor(core_leave_supervisor), .core_fc(core_fc),
    .supervisor_mode(supervisor_mode), .acc_valid(acc_valid), .acc_write(acc_write),
    .acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_rdata(acc_rdata), .acc_ready(acc_ready),
    .acc_internal(acc_int), .sys_addr(sys_addr), .boot_chip_select(boot_chip_select),
    .boot_wait_states(boot_wait_states), .cp_reinit(cp_reinit), .cp_reinit_done(cp_reinit_done),
    .pin_function(pin_func), .addr_pins_as_write_enables(addr_pins_as_write_enables),
    .global_memory_config(gmc), .clock_output_control(clk_out),
    .synthesiser_control(synthesiser_control),
    .clock_divider_control(clk_div), .synth_locked(synth_locked), .dram_read_seen(dram_read_seen),
    .dram_refresh_seen(dram_refresh_seen), .dram_ready(dram_ready));

  bsu_boot_mem bsu_boot_mem_inst (.clk(clk), .rst(rst), .delay(mem_delay), .req(boot_rd_req),
    .addr(boot_rd_addr), .ack(boot_rd_ack), .data(boot_rd_data));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic test_done();
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : test_done

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      n_fail++;
    end
  endtask : chk

  // one-cycle request, answer sampled one cycle later
  task automatic acc(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    acc_valid <= 1'b1;
    acc_write <= w;
    acc_addr <= a;
    acc_wdata <= d;
    @(posedge clk);
    acc_valid <= 1'b0;
    #1;
    ok = (acc_ready === 1'b1);
    rd = acc_rdata;
  endtask : acc

  task automatic wait_run();
    for (i = 0; i < 200 && core_run !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    if (core_run !== 1'b1) begin
      chk("core_run", core_run, 1'b1);
      test_done();
    end
  endtask : wait_run

  initial begin
    {ext_reset_req, watchdog_reset_req, bus_monitor_reset_req, double_fault_reset_req} = 4'h0;
    {core_fetch, core_leave_supervisor, acc_valid, acc_write, cp_reinit_done} = 5'h0;
    {dram_read_seen, dram_refresh_seen} = 2'h0;
    acc_addr = 32'h0;
    acc_wdata = 32'h0;
    sys_addr = 32'hFFFF_F000;
    mem_delay = 4'h3;
    n_fail = 0;
    n_tests = 0;
    rst = 1'b1;
    cause = '{8'h80, 8'h20, 8'h08, 8'h10};
    rows = '{'{1'h0, 13'h100C, 32'h0, 32'h40}, '{1'h1, 13'h100C, 32'h40, 32'h0},
      '{1'h1, 13'h1010, 32'h181, 32'h181}, '{1'h1, 13'h1014, 32'h1234_5678, 32'h1234_5678},
      '{1'h1, 13'h1018, 32'hFFFF_0003, 32'hFFFF_0003}, '{1'h1, 13'h101C, 32'h1, 32'h1},
      '{1'h1, 13'h1F00, 32'hFFFF_FFFF, 32'h0}, '{1'h1, 13'h1004, 32'h1234, 32'h1234},
      '{1'h1, 13'h1004, 32'h8000, 32'h8000}, '{1'h1, 13'h1004, 32'h1111, 32'h8000},
      '{1'h1, 13'h1008, 32'h5, 32'h0}, '{1'h1, 13'h0, 32'h33, 32'h33},
      '{1'h1, 13'h0, 32'hCC, 32'hCC}, '{1'h1, 13'h9E1, 32'hA5, 32'hA5}};
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk("wait_states", boot_wait_states, 4'hF);
    chk("boot_select", boot_chip_select, 1'b1);
    chk("fc_data", core_fc, bsu_pkg::FC_SUPER_DATA);
    wait_run();
    chk("init_sp", init_sp, 32'h0040_0000);
    chk("init_pc", init_pc, 32'h0000_0400);
    acc(1'b0, BASE, 32'h0);
    chk("early_ram", ok, 1'b0);
    acc(1'b1, MODULE_BASE_REGISTER, 32'h0070_0001);
    acc(1'b0, MODULE_BASE_REGISTER, 32'h0);
    chk("base", ok ? rd : 32'hDEAD_BEEF, 32'h0070_0001);
    // cause, pin function, global memory, option, base with valid last, then unmapped, clock and RAM rows
    for (k = 0; k < 14; k++) begin
      if (rows[k].w) acc(1'b1, BASE | {19'h0, rows[k].ofs}, rows[k].wd);
      acc(1'b0, BASE | {19'h0, rows[k].ofs}, 32'h0);
      chk("row", ok ? rd : 32'hDEAD_BEEF, rows[k].exp);
    end
    chk("we_pins", addr_pins_as_write_enables, 1'b1);
    chk("pin_func", {16'h0000, pin_func}, 32'h0000_0181);
    chk("gmc", gmc, 32'h1234_5678);
    chk("internal", acc_int, 1'b1);
    chk("clk_regs", {clk_out, clk_div}, 32'h0000_0000);
    chk("bank0_waits", boot_wait_states, 4'h3);
    @(posedge clk);
    sys_addr <= 32'h0000_0400;
    #1;
    chk("bank0_hit", boot_chip_select, 1'b1);
    @(posedge clk);
    sys_addr <= 32'h0010_0000;
    #1;
    chk("bank0_miss", boot_chip_select, 1'b0);
    acc(1'b0, 32'h0080_0000, 32'h0);
    chk("unmapped", ok, 1'b0);
    chk("outside", acc_int, 1'b0);
    acc(1'b1, BASE | 32'h1020, 32'h8001);
    for (i = 0; i < 4 && cp_reinit !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    chk("cp_reinit", cp_reinit, 1'b1);
    acc(1'b0, BASE | 32'h1020, 32'h0);
    chk("cmd_busy", rd[0], 1'b1);
    @(posedge clk);
    cp_reinit_done <= 1'b1;
    @(posedge clk);
    cp_reinit_done <= 1'b0;
    acc(1'b0, BASE | 32'h1020, 32'h0);
    chk("cmd_idle", rd[0], 1'b0);
    for (k = 0; k < 8; k++) begin
      @(posedge clk);
      {dram_refresh_seen, dram_read_seen} <= (k == 7) ? 2'h2 : 2'h1;
      @(posedge clk);
      {dram_refresh_seen, dram_read_seen} <= 2'h0;
      #1;
      if (k == 6) chk("dram_early", dram_ready, 1'b0);
    end
    for (i = 0; i < 4 && dram_ready !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    chk("dram_ready", dram_ready, 1'b1);
    acc(1'b0, BASE | 32'h1024, 32'h0);
    chk("dram_stat", ok ? rd : 32'hDEAD_BEEF, 32'h0000_0001);
    acc(1'b1, BASE | 32'h1000, 32'h7);
    acc(1'b0, BASE | 32'h1000, 32'h0);
    chk("clk_out_locked", ok ? rd : 32'hDEAD_BEEF, 32'h0000_0000);
    @(posedge clk);
    core_fetch <= 1'b1;
    core_leave_supervisor <= 1'b1;
    @(posedge clk);
    core_leave_supervisor <= 1'b0;
    #1;
    chk("fc_user", core_fc, bsu_pkg::FC_USER_PROG);
    for (k = 0; k < 4; k++) begin
      @(posedge clk);
      mem_delay <= k[3:0];
      {ext_reset_req, watchdog_reset_req, bus_monitor_reset_req, double_fault_reset_req} <=
          4'h8 >> k;
      @(posedge clk);
      {ext_reset_req, watchdog_reset_req, bus_monitor_reset_req, double_fault_reset_req} <= 4'h0;
      #1;
      wait_run();
      chk("soft_waits", boot_wait_states, 4'hF);
      chk("soft_select", boot_chip_select, 1'b1);
      chk("fc_soft", core_fc, bsu_pkg::FC_SUPER_PROG);
      chk("lock_kept", synth_locked, 1'b1);
      acc(1'b0, BASE, 32'h0);
      chk("soft_block", ok, 1'b0);
      acc(1'b1, MODULE_BASE_REGISTER, 32'h0070_0001);
      acc(1'b0, BASE | 32'h100C, 32'h0);
      chk("cause", rd, {24'h0, cause[k]});
      acc(1'b1, BASE | 32'h100C, {24'h0, cause[k]});
    end
    test_done();
  end
endmodule : bsu_boot_setup_tb
